// [push_on_off_reset_logic.sv]
// Behaviour
// - Serial data sampled on serial clock rise
// - Low button powers up main regulator
// - Status output follows button after first reset release
// - Reset held at start-up and out-of-regulation
// - Reset released after at least 140ms
// - Shutdown: request low, button high, watchdog expired
`timescale 1ns/1ps
`default_nettype none

module push_on_off_reset_logic #(
  parameter int unsigned TICK_CYCLES = power_seq_pkg::TICK_CYCLES,
  parameter int unsigned RESET_TICKS = power_seq_pkg::RESET_TICKS,
  parameter int unsigned WATCHDOG_TICKS = power_seq_pkg::WATCHDOG_TICKS,
  parameter int unsigned SER_WIDTH = power_seq_pkg::SER_WIDTH
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic button_n_i,
  input wire logic shutdown_hold_i,
  input wire logic main_reg_ok_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic ser_select_n_i,
  input wire logic [power_seq_pkg::AUX_REG_COUNT-1:0] aux_reg_req_i,
  output logic main_regulator_en_o,
  output logic [power_seq_pkg::AUX_REG_COUNT-1:0] aux_reg_en_o,
  output logic system_reset_out_n_o,
  output logic button_state_output_o,
  output logic [SER_WIDTH-1:0] ser_word_o,
  output logic ser_bit_valid_o
);

  if (TICK_CYCLES < 1 || TICK_CYCLES > (1 << power_seq_pkg::TICK_CNT_W)) begin : g_tick_range
    $error("TICK_CYCLES out of range");
  end
  if (RESET_TICKS < 1 || RESET_TICKS >= (1 << power_seq_pkg::TIMER_W)) begin : g_reset_range
    $error("RESET_TICKS out of range");
  end
  if (WATCHDOG_TICKS < 1 || WATCHDOG_TICKS >= (1 << power_seq_pkg::TIMER_W)) begin : g_wd_range
    $error("WATCHDOG_TICKS out of range");
  end
  // Shift register needs at least two bits
  if (SER_WIDTH < 2) begin : g_ser_range
    $error("SER_WIDTH out of range");
  end

  localparam logic [power_seq_pkg::TICK_CNT_W-1:0] TICK_LAST = power_seq_pkg::TICK_CNT_W'(TICK_CYCLES - 1);
  localparam logic [power_seq_pkg::TIMER_W-1:0] RESET_LAST = power_seq_pkg::TIMER_W'(RESET_TICKS);
  localparam logic [power_seq_pkg::TIMER_W-1:0] WD_LAST = power_seq_pkg::TIMER_W'(WATCHDOG_TICKS);

  power_seq_pkg::pin_in_type pins_raw;
  power_seq_pkg::pin_in_type pins;

  assign pins_raw = '{button_n: button_n_i, shutdown_hold: shutdown_hold_i, main_reg_ok: main_reg_ok_i,
                      ser_clk: ser_clk_i, ser_data: ser_data_i, ser_select_n: ser_select_n_i};

  pin_sync #(
    .WIDTH(power_seq_pkg::PIN_COUNT),
    .RST_VAL(power_seq_pkg::PIN_RST)
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pins_raw),
    .sync_o(pins)
  );

  // Time base: free-running 1 ms enable pulse
  logic [power_seq_pkg::TICK_CNT_W-1:0] tick_cnt_reg;
  logic [power_seq_pkg::TICK_CNT_W-1:0] tick_cnt_next;
  logic tick;

  always_comb begin
    tick = (tick_cnt_reg == TICK_LAST);
    tick_cnt_next = tick ? power_seq_pkg::TICK_CNT_RST : tick_cnt_reg + 1'b1;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_reg <= power_seq_pkg::TICK_CNT_RST;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // Power state, timers and outputs
  power_seq_pkg::power_state_type state_reg;
  power_seq_pkg::power_state_type state_next;
  logic [power_seq_pkg::TIMER_W-1:0] rst_timer_reg;
  logic [power_seq_pkg::TIMER_W-1:0] rst_timer_next;
  logic [power_seq_pkg::TIMER_W-1:0] wd_timer_reg;
  logic [power_seq_pkg::TIMER_W-1:0] wd_timer_next;
  logic wd_expired_reg;
  logic wd_expired_next;
  logic init_done_reg;
  logic init_done_next;
  logic reset_n_reg;
  logic reset_n_next;
  logic main_en_reg;
  logic main_en_next;
  logic [power_seq_pkg::AUX_REG_COUNT-1:0] aux_en_reg;
  logic [power_seq_pkg::AUX_REG_COUNT-1:0] aux_en_next;
  logic button_state_reg;
  logic button_state_next;
  logic reset_cause;

  always_comb begin
    state_next = state_reg;
    rst_timer_next = rst_timer_reg;
    wd_timer_next = wd_timer_reg;
    wd_expired_next = wd_expired_reg;
    init_done_next = init_done_reg;
    reset_n_next = reset_n_reg;
    reset_cause = 1'b1;
    unique case (state_reg)
      power_seq_pkg::PWR_OFF: begin
        rst_timer_next = power_seq_pkg::TIMER_RST;
        wd_timer_next = power_seq_pkg::TIMER_RST;
        wd_expired_next = 1'b0;
        init_done_next = 1'b0;
        reset_n_next = 1'b0;
        if (!pins.button_n) begin
          state_next = power_seq_pkg::PWR_ON;
        end
      end
      power_seq_pkg::PWR_ON: begin
        // Regulation is meaningless until the regulator has been enabled a cycle
        reset_cause = !pins.main_reg_ok;
        if (reset_cause) begin
          reset_n_next = 1'b0;
          rst_timer_next = power_seq_pkg::TIMER_RST;
        end else if (!reset_n_reg && tick) begin
          if (rst_timer_reg == RESET_LAST - 1'b1) begin
            reset_n_next = 1'b1;
            init_done_next = 1'b1;
          end
          rst_timer_next = rst_timer_reg + 1'b1;
        end
        if (!wd_expired_reg && tick) begin
          wd_timer_next = wd_timer_reg + 1'b1;
          if (wd_timer_reg == WD_LAST - 1'b1) begin
            wd_expired_next = 1'b1;
          end
        end
        // Host may hold the pin high to keep power
        if (wd_expired_reg && !pins.shutdown_hold && pins.button_n) begin
          state_next = power_seq_pkg::PWR_OFF;
          reset_n_next = 1'b0;
        end
      end
      default: begin
        state_next = power_seq_pkg::PWR_OFF;
      end
    endcase
    main_en_next = (state_next == power_seq_pkg::PWR_ON);
    aux_en_next = main_en_next ? aux_reg_req_i : '0;
    // Before first release the output reads idle high
    button_state_next = init_done_next ? pins.button_n : 1'b1;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= power_seq_pkg::PWR_OFF;
      rst_timer_reg <= power_seq_pkg::TIMER_RST;
      wd_timer_reg <= power_seq_pkg::TIMER_RST;
      wd_expired_reg <= 1'b0;
      init_done_reg <= 1'b0;
      reset_n_reg <= 1'b0;
      main_en_reg <= 1'b0;
      aux_en_reg <= '0;
      button_state_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      rst_timer_reg <= rst_timer_next;
      wd_timer_reg <= wd_timer_next;
      wd_expired_reg <= wd_expired_next;
      init_done_reg <= init_done_next;
      reset_n_reg <= reset_n_next;
      main_en_reg <= main_en_next;
      aux_en_reg <= aux_en_next;
      button_state_reg <= button_state_next;
    end
  end

  // Serial sampling on rising serial clock, select active low
  logic ser_clk_prev_reg;
  logic [SER_WIDTH-1:0] ser_shift_reg;
  logic [SER_WIDTH-1:0] ser_shift_next;
  logic ser_valid_reg;
  logic ser_valid_next;

  always_comb begin
    ser_shift_next = ser_shift_reg;
    ser_valid_next = 1'b0;
    // Port is dead while unpowered
    if (main_en_reg && !pins.ser_select_n && pins.ser_clk && !ser_clk_prev_reg) begin
      ser_shift_next = {ser_shift_reg[SER_WIDTH-2:0], pins.ser_data};
      ser_valid_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ser_clk_prev_reg <= 1'b0;
      ser_shift_reg <= power_seq_pkg::SER_RST;
      ser_valid_reg <= 1'b0;
    end else begin
      ser_clk_prev_reg <= pins.ser_clk;
      ser_shift_reg <= ser_shift_next;
      ser_valid_reg <= ser_valid_next;
    end
  end

  assign main_regulator_en_o = main_en_reg;
  assign aux_reg_en_o = aux_en_reg;
  assign system_reset_out_n_o = reset_n_reg;
  assign button_state_output_o = button_state_reg;
  assign ser_word_o = ser_shift_reg;
  assign ser_bit_valid_o = ser_valid_reg;

endmodule

`default_nettype wire

// [power_seq_pkg.sv]
package power_seq_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;

  // Reset release timeout, minimum
  localparam int unsigned RESET_TIMEOUT_MS = 140;
  // Watchdog expiry after power-up
  localparam int unsigned WATCHDOG_MS = 35;

  // One extra tick covers the unknown phase of the free-running tick
  localparam int unsigned RESET_TICKS = (RESET_TIMEOUT_MS * 1000 + TICK_US - 1) / TICK_US + 1;
  localparam int unsigned WATCHDOG_TICKS = (WATCHDOG_MS * 1000 + TICK_US - 1) / TICK_US + 1;

  localparam int unsigned TICK_CNT_W = 16;
  localparam int unsigned TIMER_W = 8;
  localparam int unsigned SER_WIDTH = 8;
  localparam int unsigned AUX_REG_COUNT = 4;

  // Values after reset
  localparam logic [TICK_CNT_W-1:0] TICK_CNT_RST = 16'h0000;
  localparam logic [TIMER_W-1:0] TIMER_RST = 8'h00;
  localparam logic [SER_WIDTH-1:0] SER_RST = 8'h00;
  localparam int unsigned PIN_COUNT = 6;

  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_ON
  } power_state_type;

  // Asynchronous pins, synchronised as one group
  typedef struct packed {
    logic button_n;
    logic shutdown_hold;
    logic main_reg_ok;
    logic ser_clk;
    logic ser_data;
    logic ser_select_n;
  } pin_in_type;

  localparam pin_in_type PIN_RST = '{button_n: 1'b1, shutdown_hold: 1'b0, main_reg_ok: 1'b0,
                                     ser_clk: 1'b0, ser_data: 1'b0, ser_select_n: 1'b1};

endpackage

// [pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1_reg <= RST_VAL;
      stage2_reg <= RST_VAL;
    end else begin
      stage1_reg <= async_i;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_o = stage2_reg;

endmodule

`default_nettype wire

// [push_on_off_reset_logic_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module push_on_off_reset_logic_chk #(
  parameter int unsigned TICK_CYCLES = 10,
  parameter int unsigned RESET_TICKS = 5,
  parameter int unsigned WATCHDOG_TICKS = 3,
  parameter int unsigned SER_WIDTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic button_n_i,
  input wire logic shutdown_hold_i,
  input wire logic main_reg_ok_i,
  input wire logic main_regulator_en_o,
  input wire logic [power_seq_pkg::AUX_REG_COUNT-1:0] aux_reg_en_o,
  input wire logic system_reset_out_n_o,
  input wire logic button_state_output_o,
  input wire logic [SER_WIDTH-1:0] ser_word_o,
  input wire logic ser_bit_valid_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  int ok_reg, ok_next, on_reg, on_next;
  logic rel_reg, rel_next;
  // ok_reg is counted at the pin, so it leads the design by the sync delay
  always_comb begin
    ok_next = (main_reg_ok_i && main_regulator_en_o) ? ok_reg + 1 : 0;
    on_next = main_regulator_en_o ? on_reg + 1 : 0;
    rel_next = main_regulator_en_o && (rel_reg || system_reset_out_n_o);
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ok_reg <= 0;
      on_reg <= 0;
      rel_reg <= 1'b0;
    end else begin
      ok_reg <= ok_next;
      on_reg <= on_next;
      rel_reg <= rel_next;
    end
  end
  sequence s_press;
    (!button_n_i && !main_regulator_en_o) [*3];
  endsequence
  sequence s_steady;
    (rel_reg && $stable(button_n_i)) [*5];
  endsequence
  a_power_on_press: assert property (s_press |=> main_regulator_en_o)
    else $error("no power-up on button");
  a_status_follow: assert property (s_steady |-> button_state_output_o == button_n_i)
    else $error("status differs from button");
  a_status_idle: assert property (!rel_reg && !system_reset_out_n_o |-> button_state_output_o)
    else $error("status low before power-up");
  a_reset_fault: assert property (!main_reg_ok_i [*5] |-> !system_reset_out_n_o)
    else $error("reset high out of regulation");
  a_reset_hold: assert property ($rose(system_reset_out_n_o) |-> ok_reg >= (RESET_TICKS - 1) * TICK_CYCLES)
    else $error("reset released early");
  a_shutdown_gate: assert property ($fell(main_regulator_en_o) |-> on_reg >= (WATCHDOG_TICKS - 1) * TICK_CYCLES
    && !$past(shutdown_hold_i, 3) && $past(button_n_i, 3)) else $error("power-down without cause");
  a_all_off: assert property (!main_regulator_en_o |-> aux_reg_en_o == '0 && !system_reset_out_n_o)
    else $error("output enabled while off");
  a_serial_shift: assert property (ser_bit_valid_o |-> main_regulator_en_o
    && ser_word_o[SER_WIDTH-1:1] == $past(ser_word_o[SER_WIDTH-2:0]) ##1 !ser_bit_valid_o)
    else $error("bad serial shift");
endmodule
bind push_on_off_reset_logic push_on_off_reset_logic_chk #(.TICK_CYCLES(TICK_CYCLES),
  .RESET_TICKS(RESET_TICKS), .WATCHDOG_TICKS(WATCHDOG_TICKS), .SER_WIDTH(SER_WIDTH)) u_chk (.sys_clk_i,
  .rst_n_i, .button_n_i,
  .shutdown_hold_i, .main_reg_ok_i, .main_regulator_en_o, .aux_reg_en_o, .system_reset_out_n_o,
  .button_state_output_o, .ser_word_o, .ser_bit_valid_o);
`default_nettype wire

// [host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic reset_n_i,
  input wire logic status_i,
  output logic hold_o
);
  logic hold_reg, hold_next;
  // Off request wins, so a button press drops keep-on; the supply stays on until the button is released
  always_comb hold_next = !status_i ? 1'b0 : (reset_n_i ? 1'b1 : hold_reg);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) hold_reg <= 1'b0;
    else hold_reg <= hold_next;
  end
  assign hold_o = hold_reg;
endmodule
`default_nettype wire

// [push_on_off_reset_logic_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module push_on_off_reset_logic_tb;
  localparam int unsigned TC = 10;
  localparam int unsigned RT = 5;
  // Watchdog outlasts reset release, so the host raises keep-on in time
  localparam int unsigned WT = 8;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic button_n = 1'b1;
  logic reg_ok = 1'b0;
  logic ser_clk = 1'b0;
  logic ser_data = 1'b0;
  logic sel_n = 1'b1;
  logic [3:0] aux_req = 4'h0;
  logic hold, main_en, reset_n, status, valid;
  logic [3:0] aux_en;
  logic [7:0] word;
  int failures = 0;
  int cmp_count = 0;
  int exp_word = 0;
  int pulses = 0;
  int n;
  always #25 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (valid === 1'b1) pulses++;
  push_on_off_reset_logic #(.TICK_CYCLES(TC), .RESET_TICKS(RT), .WATCHDOG_TICKS(WT)) u_push_on_off_reset_logic (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .button_n_i(button_n), .shutdown_hold_i(hold), .main_reg_ok_i(reg_ok),
    .ser_clk_i(ser_clk), .ser_data_i(ser_data), .ser_select_n_i(sel_n), .aux_reg_req_i(aux_req),
    .main_regulator_en_o(main_en), .aux_reg_en_o(aux_en), .system_reset_out_n_o(reset_n),
    .button_state_output_o(status), .ser_word_o(word), .ser_bit_valid_o(valid));
  host_model u_host_model (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .reset_n_i(reset_n), .status_i(status),
    .hold_o(hold));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic clk(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic wait_en(input logic v, input int lim, output int k);
    for (k = 0; k < lim && main_en !== v; k++) @(negedge sys_clk);
  endtask
  task automatic wait_rel(output int k);
    for (k = 0; k < 400 && reset_n !== 1'b1; k++) @(negedge sys_clk);
  endtask
  // Bit cells of 6 cycles keep both clock phases above the sync minimum
  task automatic send(input logic [7:0] b, input logic s);
    int p0;
    clk(1);
    p0 = pulses;
    sel_n <= s;
    for (int i = 7; i >= 0; i--) begin
      ser_data <= b[i];
      clk(3);
      ser_clk <= 1'b1;
      clk(3);
      ser_clk <= 1'b0;
      if (!s) exp_word = ((exp_word << 1) | b[i]) & 8'hff;
    end
    clk(4);
    sel_n <= 1'b1;
    ser_data <= ~ser_data;
    @(negedge sys_clk);
    chk(word, exp_word);
    chk(pulses - p0, s ? 0 : 8);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clk(5000);
    failures++;
    summarize();
  end
  initial begin
    n = $urandom(97);
    clk(12);
    rst_n <= 1'b1;
    clk(3);
    button_n <= 1'b0;
    aux_req <= 4'($urandom);
    wait_en(1'b1, 20, n);
    chk(n < 8, 1'b1);
    clk(2);
    @(negedge sys_clk);
    chk({aux_en, reset_n, status}, {aux_req, 2'b01});
    clk(1);
    button_n <= 1'b1;
    wait_en(1'b0, 400, n);
    chk(n + 5 >= (WT - 1) * TC && n <= WT * TC + 8, 1'b1);
    clk(10);
    @(negedge sys_clk);
    chk({main_en, aux_en, reset_n}, 6'h00);
    $display("power-up without keep-on done");
    clk(1);
    reg_ok <= 1'b1;
    button_n <= 1'b0;
    wait_en(1'b1, 20, n);
    chk(status, 1'b1);
    clk(1);
    button_n <= 1'b1;
    wait_rel(n);
    chk(n + 2 >= (RT - 1) * TC && n <= RT * TC + 8, 1'b1);
    clk(1);
    aux_req <= 4'($urandom);
    for (n = 0; n < 4; n++) send(8'($urandom), n == 3);
    chk(aux_en, aux_req);
    $display("serial and release done");
    clk(1);
    reg_ok <= 1'b0;
    clk(6);
    @(negedge sys_clk);
    chk(reset_n, 1'b0);
    clk(1);
    reg_ok <= 1'b1;
    wait_rel(n);
    chk(n + 2 >= (RT - 1) * TC && n <= RT * TC + 8, 1'b1);
    clk(1);
    button_n <= 1'b0;
    clk(8);
    @(negedge sys_clk);
    chk({main_en, status}, 2'b10);
    clk(1);
    button_n <= 1'b1;
    wait_en(1'b0, 20, n);
    chk(n < 8, 1'b1);
    clk(2);
    @(negedge sys_clk);
    chk({aux_en, reset_n, status}, 6'h01);
    $display("off request done");
    summarize();
  end
endmodule
`default_nettype wire
